// ### verilog/rfms_pkg.sv
// rfms_pkg: constants, opcodes and carrier types for the flow/move/shift executor.
// assumes a single core clock and one instruction executed per clock.
package rfms_pkg;

  // instruction word layout (22 bits): op | mem | dst | src | data
  localparam int INSTR_W = 22;
  localparam int PC_W = 16;
  localparam int DATA_W = 8;

  // opcodes (field op, 5 bits)
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_JMP_IMM = 5'h01;
  localparam logic [4:0] OP_JMP_IP = 5'h02;
  localparam logic [4:0] OP_JCC_IMM = 5'h03;
  localparam logic [4:0] OP_JCC_IP = 5'h04;
  localparam logic [4:0] OP_CALL_IMM = 5'h05;
  localparam logic [4:0] OP_CALL_IP = 5'h06;
  localparam logic [4:0] OP_CALLS_IMM = 5'h07;
  localparam logic [4:0] OP_CALLS_IP = 5'h08;
  localparam logic [4:0] OP_RET = 5'h09;
  localparam logic [4:0] OP_RETS = 5'h0A;
  localparam logic [4:0] OP_RETI = 5'h0B;
  localparam logic [4:0] OP_PUSH = 5'h0C;
  localparam logic [4:0] OP_POP = 5'h0D;
  localparam logic [4:0] OP_MOV_IMM = 5'h0E;
  localparam logic [4:0] OP_MOV_LD = 5'h0F;
  localparam logic [4:0] OP_MOV_ST = 5'h10;
  localparam logic [4:0] OP_MOV_ST_IMM = 5'h11;
  localparam logic [4:0] OP_CMVD = 5'h12;
  localparam logic [4:0] OP_CMVS = 5'h13;
  localparam logic [4:0] OP_SHL = 5'h14;
  localparam logic [4:0] OP_SHLC = 5'h15;
  localparam logic [4:0] OP_SHR = 5'h16;
  localparam logic [4:0] OP_SHRC = 5'h17;
  localparam logic [4:0] OP_SHRA = 5'h18;

  // branch_condition codes, carried in the dst field of a conditional jump
  localparam logic [3:0] COND_C = 4'h0;
  localparam logic [3:0] COND_NC = 4'h1;
  localparam logic [3:0] COND_Z = 4'h2;
  localparam logic [3:0] COND_NZ = 4'h3;
  localparam logic [3:0] COND_V = 4'h4;
  localparam logic [3:0] COND_NV = 4'h5;

  // internal register indices; below REG_IPH all are general purpose
  localparam logic [3:0] REG_IPH = 4'hC;
  localparam logic [3:0] REG_IPL = 4'hD;
  localparam logic [3:0] REG_STAT = 4'hE;
  localparam logic [3:0] REG_ACC = 4'hF;
  localparam int NUM_GPR = 12;

  // status register field, reset values, pc step and default stack depth
  localparam int GLOBAL_IRQ_ENABLE_BIT = 5;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] IP_RESET = 16'h0000;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam int STACK_DEPTH_DEF = 8;

  // decoded instruction word
  typedef struct packed {
    logic [4:0] op;
    logic mem;
    logic [3:0] dst;
    logic [3:0] src;
    logic [7:0] data;
  } rfms_instr_type;

  // arithmetic flags
  typedef struct packed {
    logic c;
    logic v;
    logic z;
  } rfms_flags_type;

  // data memory write request
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } rfms_dmem_wr_type;

endpackage : rfms_pkg

// ### verilog/rfms_call_lifo.sv
// rfms_call_lifo: hardware return stack, entry 0 is the top.
// assumes push and pop never arrive together; the executor guarantees it.
module rfms_call_lifo #(
  parameter int DEPTH = rfms_pkg::STACK_DEPTH_DEF,
  parameter int WIDTH = rfms_pkg::PC_W
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [WIDTH-1:0] din_i,
  output logic [WIDTH-1:0] top_o
);

  // refuse a stack with no entry
  if (DEPTH < 1) begin : g_chk
    $error("call lifo needs at least one entry");
  end

  logic [WIDTH-1:0] entry [0:DEPTH-1]; // stacked return addresses
  logic [WIDTH-1:0] next_entry [0:DEPTH-1];

  // each level takes its neighbour; an overflow drops the deepest entry silently
  for (genvar gi = 0; gi < DEPTH; gi++) begin : g_lvl
    always_comb begin
      next_entry[gi] = entry[gi];
      if (push_i) begin
        next_entry[gi] = (gi == 0) ? din_i : entry[(gi == 0) ? 0 : gi - 1];
      end else if (pop_i) begin
        next_entry[gi] = (gi == DEPTH - 1) ? '0 : entry[(gi == DEPTH - 1) ? gi : gi + 1];
      end
    end
    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        entry[gi] <= '0;
      end else begin
        entry[gi] <= next_entry[gi];
      end
    end
  end

  // top read straight from the register
  assign top_o = entry[0];

endmodule : rfms_call_lifo

// ### verilog/rfms_exec.sv
// rfms_exec: one-cycle executor for jumps, calls, returns, moves and shifts.
// assumes instr_i is the word at pc_o and dmem_rdata_i the data word it addresses.
// Functional notes
// RULE1 - jumps load immediate or index; conditional if true
// RULE2 - call deepens stack, stores PC+1, jumps
// RULE3 - linked call saves PC+1 in index; leaf return
// RULE4 - return pops top entry into PC
// RULE5 - interrupt return also sets global enable
// RULE6 - push advances PC, stacks program index
// RULE7 - pop advances PC, unstacks into program index
// RULE8 - loads write register and accumulator; stores don't
// RULE9 - carry-clear move writes register only if C=0
// RULE10 - carry-set move writes register only if C=1
// RULE11 - left shift: bit0 cleared, old bit7 to carry
// RULE12 - left rotate: carry in, old bit7 out
// RULE13 - right shift: bit7 cleared, old bit0 to carry
// RULE14 - right rotate: carry in bit7, bit0 out
// RULE15 - arithmetic right shift keeps sign bit
// RULE16 - 22-bit words, every instruction one cycle
// RULE17 - zero flag set when accumulator is zero
// RULE18 - global enable is status bit 5
// RULE19 - shift overflow marks sign change
module rfms_exec #(
  parameter int STACK_DEPTH = rfms_pkg::STACK_DEPTH_DEF
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire rfms_pkg::rfms_instr_type instr_i,
  input wire logic [7:0] dmem_rdata_i,
  output logic [15:0] pc_o,
  output logic [7:0] acc_o,
  output rfms_pkg::rfms_flags_type flags_o,
  output logic [15:0] program_index_o,
  output logic [7:0] status_o,
  output logic global_irq_enable_o,
  output rfms_pkg::rfms_dmem_wr_type dmem_wr_o
);

  if (STACK_DEPTH < 1) begin : g_chk
    $error("stack depth must be at least one");
  end

  // condition evaluation, shared by both conditional jump forms
  function automatic logic cond_true(input logic [3:0] branch_condition,
      input rfms_pkg::rfms_flags_type f);
    logic r;
    r = 1'b0;
    case (branch_condition)
      rfms_pkg::COND_C: r = f.c;
      rfms_pkg::COND_NC: r = !f.c;
      rfms_pkg::COND_Z: r = f.z;
      rfms_pkg::COND_NZ: r = !f.z;
      rfms_pkg::COND_V: r = f.v;
      rfms_pkg::COND_NV: r = !f.v;
      default: r = 1'b0; // unknown codes never branch
    endcase
    return r;
  endfunction : cond_true

  rfms_pkg::rfms_instr_type ins; // current word, one cycle per word [RULE16]
  logic [15:0] pc; // program counter
  logic [15:0] ip; // program_index
  logic [7:0] acc; // accumulator
  logic [7:0] stat; // status register
  rfms_pkg::rfms_flags_type flags; // c, v, z
  rfms_pkg::rfms_dmem_wr_type dmem_wr; // registered store request
  logic [7:0] gpr [0:rfms_pkg::NUM_GPR-1]; // general purpose registers
  logic [15:0] next_pc;
  logic [15:0] next_ip;
  logic [7:0] next_acc;
  logic [7:0] next_stat;
  rfms_pkg::rfms_flags_type next_flags;
  rfms_pkg::rfms_dmem_wr_type next_dmem_wr;
  logic [7:0] next_gpr [0:rfms_pkg::NUM_GPR-1];
  logic [15:0][7:0] reg_view; // all sixteen registers by index
  logic [15:0] target; // 16-bit immediate jump target
  logic [15:0] pc_inc; // address of the following word
  logic [15:0] lifo_top; // top return-stack entry
  logic lifo_push;
  logic lifo_pop;
  logic [15:0] lifo_din;
  logic [7:0] src_val; // register or data memory operand
  logic [7:0] res; // accumulator result
  logic acc_load; // result goes to accumulator and zero flag
  logic wr_en; // result goes to destination register
  logic shift_op; // result also updates carry and overflow
  logic cout;

  assign ins = instr_i;
  assign target = {ins.dst, ins.src, ins.data};
  assign pc_inc = pc + rfms_pkg::PC_STEP;

  // register read view; generated so the index map stays in one place
  for (genvar gi = 0; gi < rfms_pkg::NUM_GPR; gi++) begin : g_view
    assign reg_view[gi] = gpr[gi];
  end
  assign reg_view[rfms_pkg::REG_IPH] = ip[15:8];
  assign reg_view[rfms_pkg::REG_IPL] = ip[7:0];
  assign reg_view[rfms_pkg::REG_STAT] = stat;
  assign reg_view[rfms_pkg::REG_ACC] = acc;

  // return stack kept in its own small memory
  rfms_call_lifo #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(rfms_pkg::PC_W)
  ) u_call_lifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .push_i(lifo_push),
    .pop_i(lifo_pop),
    .din_i(lifo_din),
    .top_o(lifo_top)
  );

  // next-state computation for the whole instruction, one cycle
  always_comb begin
    next_pc = pc_inc;
    next_ip = ip;
    next_acc = acc;
    next_stat = stat;
    next_flags = flags;
    next_dmem_wr = '0; // store strobe lasts one cycle
    next_gpr = gpr;
    lifo_push = 1'b0;
    lifo_pop = 1'b0;
    lifo_din = pc_inc;
    src_val = ins.mem ? dmem_rdata_i : reg_view[ins.src];
    res = src_val;
    acc_load = 1'b0;
    wr_en = 1'b0;
    shift_op = 1'b0;
    cout = flags.c;
    case (ins.op)
      rfms_pkg::OP_JMP_IMM: next_pc = target; // [RULE1]
      rfms_pkg::OP_JMP_IP: next_pc = ip; // [RULE1]
      rfms_pkg::OP_JCC_IMM: begin
        if (cond_true(ins.dst, flags)) next_pc = {ins.src, ins.src, ins.data}; // [RULE1]
      end
      rfms_pkg::OP_JCC_IP: begin
        if (cond_true(ins.dst, flags)) next_pc = ip; // [RULE1]
      end
      rfms_pkg::OP_CALL_IMM, rfms_pkg::OP_CALL_IP: begin
        lifo_push = 1'b1; // [RULE2]
        lifo_din = pc_inc;
        next_pc = (ins.op == rfms_pkg::OP_CALL_IMM) ? target : ip;
      end
      rfms_pkg::OP_CALLS_IMM, rfms_pkg::OP_CALLS_IP: begin
        next_ip = pc_inc; // stack untouched [RULE3]
        next_pc = (ins.op == rfms_pkg::OP_CALLS_IMM) ? target : ip;
      end
      rfms_pkg::OP_RETS: next_pc = ip; // leaf return [RULE3]
      rfms_pkg::OP_RET, rfms_pkg::OP_RETI: begin
        lifo_pop = 1'b1; // [RULE4]
        next_pc = lifo_top;
        if (ins.op == rfms_pkg::OP_RETI) begin
          next_stat[rfms_pkg::GLOBAL_IRQ_ENABLE_BIT] = 1'b1; // [RULE5] [RULE18]
        end
      end
      rfms_pkg::OP_PUSH: begin
        lifo_push = 1'b1; // [RULE6]
        lifo_din = ip;
      end
      rfms_pkg::OP_POP: begin
        lifo_pop = 1'b1; // [RULE7]
        next_ip = lifo_top;
      end
      rfms_pkg::OP_MOV_IMM: begin
        res = ins.data; // [RULE8]
        acc_load = 1'b1;
        wr_en = 1'b1;
      end
      rfms_pkg::OP_MOV_LD: begin
        acc_load = 1'b1; // register or memory source [RULE8]
        wr_en = 1'b1;
      end
      rfms_pkg::OP_MOV_ST: begin
        next_dmem_wr = '{we: 1'b1, addr: ins.data, data: reg_view[ins.src]}; // [RULE8]
      end
      rfms_pkg::OP_MOV_ST_IMM: begin
        next_dmem_wr = '{we: 1'b1, addr: {ins.dst, ins.src}, data: ins.data}; // [RULE8]
      end
      rfms_pkg::OP_CMVD: begin
        acc_load = 1'b1;
        wr_en = !flags.c; // [RULE9]
      end
      rfms_pkg::OP_CMVS: begin
        acc_load = 1'b1;
        wr_en = flags.c; // [RULE10]
      end
      rfms_pkg::OP_SHL: begin
        res = {src_val[6:0], 1'b0}; // [RULE11]
        cout = src_val[7];
        shift_op = 1'b1;
      end
      rfms_pkg::OP_SHLC: begin
        res = {src_val[6:0], flags.c}; // [RULE12]
        cout = src_val[7];
        shift_op = 1'b1;
      end
      rfms_pkg::OP_SHR: begin
        res = {1'b0, src_val[7:1]}; // [RULE13]
        cout = src_val[0];
        shift_op = 1'b1;
      end
      rfms_pkg::OP_SHRC: begin
        res = {flags.c, src_val[7:1]}; // [RULE14]
        cout = src_val[0];
        shift_op = 1'b1;
      end
      rfms_pkg::OP_SHRA: begin
        res = {src_val[7], src_val[7:1]}; // [RULE15]
        cout = src_val[0];
        shift_op = 1'b1;
      end
      default: begin
      end
    endcase
    if (shift_op) begin
      acc_load = 1'b1;
      wr_en = 1'b1;
      next_flags.c = cout;
      next_flags.v = res[7] ^ src_val[7]; // sign change [RULE19]
    end
    if (wr_en) begin
      // destination write; accumulator index is covered by the load below
      if (ins.dst < rfms_pkg::REG_IPH) begin
        next_gpr[ins.dst] = res;
      end else if (ins.dst == rfms_pkg::REG_IPH) begin
        next_ip[15:8] = res;
      end else if (ins.dst == rfms_pkg::REG_IPL) begin
        next_ip[7:0] = res;
      end else if (ins.dst == rfms_pkg::REG_STAT) begin
        next_stat = res;
      end
    end
    if (acc_load) begin
      next_acc = res;
      next_flags.z = (res == 8'h00); // [RULE17]
    end
  end

  // architectural state registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pc <= rfms_pkg::PC_RESET;
      ip <= rfms_pkg::IP_RESET;
      acc <= rfms_pkg::REG_RESET;
      stat <= rfms_pkg::STAT_RESET;
      flags <= '0;
      dmem_wr <= '0;
      for (int i = 0; i < rfms_pkg::NUM_GPR; i++) gpr[i] <= rfms_pkg::REG_RESET;
    end else begin
      pc <= next_pc;
      ip <= next_ip;
      acc <= next_acc;
      stat <= next_stat;
      flags <= next_flags;
      dmem_wr <= next_dmem_wr;
      gpr <= next_gpr;
    end
  end

  // outputs are the state flops themselves
  assign pc_o = pc;
  assign acc_o = acc;
  assign flags_o = flags;
  assign program_index_o = ip;
  assign status_o = stat;
  assign global_irq_enable_o = stat[rfms_pkg::GLOBAL_IRQ_ENABLE_BIT]; // [RULE18]
  assign dmem_wr_o = dmem_wr;

  // checks on the executed instruction, seen one edge later
  property p_jump;
    @(posedge ref_clk_i) disable iff (srst_i)
      (ins.op == rfms_pkg::OP_JMP_IMM) |=> (pc == $past(target));
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded"); // [RULE1]

  property p_jcc_fall;
    @(posedge ref_clk_i) disable iff (srst_i)
      (ins.op == rfms_pkg::OP_JCC_IP && !cond_true(ins.dst, flags)) |=> (pc == $past(pc_inc));
  endproperty
  a_jcc_fall: assert property (p_jcc_fall) else $error("false jump did not fall through"); // [RULE1]

  property p_call;
    @(posedge ref_clk_i) disable iff (srst_i)
      (ins.op == rfms_pkg::OP_CALL_IMM) |=> (lifo_top == $past(pc_inc) && pc == $past(target));
  endproperty
  a_call: assert property (p_call) else $error("call address lost"); // [RULE2]

  property p_calls;
    @(posedge ref_clk_i) disable iff (srst_i)
      (ins.op == rfms_pkg::OP_CALLS_IMM) |=> (ip == $past(pc_inc) && pc == $past(target));
  endproperty
  a_calls: assert property (p_calls) else $error("linked call wrong"); // [RULE3]

  property p_ret;
    @(posedge ref_clk_i) disable iff (srst_i)
      (ins.op == rfms_pkg::OP_RET) |=> (pc == $past(lifo_top));
  endproperty
  a_ret: assert property (p_ret) else $error("return address wrong"); // [RULE4]

  property p_reti;
    @(posedge ref_clk_i) disable iff (srst_i)
      (ins.op == rfms_pkg::OP_RETI) |=> global_irq_enable_o;
  endproperty
  a_reti: assert property (p_reti) else $error("interrupt enable not set"); // [RULE5]

  property p_push;
    @(posedge ref_clk_i) disable iff (srst_i)
      (ins.op == rfms_pkg::OP_PUSH) |=> (lifo_top == $past(ip) && pc == $past(pc_inc));
  endproperty
  a_push: assert property (p_push) else $error("push wrong"); // [RULE6]

  property p_pop;
    @(posedge ref_clk_i) disable iff (srst_i)
      (ins.op == rfms_pkg::OP_POP) |=> (ip == $past(lifo_top));
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong"); // [RULE7]

  property p_store;
    @(posedge ref_clk_i) disable iff (srst_i)
      (ins.op == rfms_pkg::OP_MOV_ST) |=> ($stable(acc) && $stable(flags) && dmem_wr.we);
  endproperty
  a_store: assert property (p_store) else $error("store touched accumulator"); // [RULE8]

  property p_zero;
    @(posedge ref_clk_i) disable iff (srst_i)
      acc_load |=> (flags.z == (acc == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag mismatch"); // [RULE17]

  property p_shl;
    @(posedge ref_clk_i) disable iff (srst_i)
      (ins.op == rfms_pkg::OP_SHL) |=> (acc[0] == 1'b0 && flags.c == $past(src_val[7]));
  endproperty
  a_shl: assert property (p_shl) else $error("left shift wrong"); // [RULE11]

  property p_shra;
    @(posedge ref_clk_i) disable iff (srst_i)
      (ins.op == rfms_pkg::OP_SHRA) |=> (acc[7] == $past(src_val[7]) && !flags.v);
  endproperty
  a_shra: assert property (p_shra) else $error("arithmetic shift wrong"); // [RULE15]

endmodule : rfms_exec

// ### verification/rfms_mem_model.sv
// rfms_mem_model: behavioural program and data memory facing the executor.
// assumes one core clock; the bench loads words and bytes by hierarchical writes.
module rfms_mem_model (
  input wire logic ref_clk_i,
  input wire logic [15:0] pc_i,
  input wire rfms_pkg::rfms_dmem_wr_type dmem_wr_i,
  output rfms_pkg::rfms_instr_type instr_o,
  output logic [7:0] dmem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [21:0] prog [0:65535]; // program words, zero decodes as a no-op
  logic [7:0] dmem [0:255]; // data bytes, read at the data field, written at the store request address

  // clear both stores so nothing unknown is ever fetched
  initial begin
    for (int i = 0; i < 65536; i++) begin
      prog[i] = '0;
    end
    for (int i = 0; i < 256; i++) begin
      dmem[i] = 8'h00;
    end
  end

  // fetch is combinational: the word must stand in the cycle it executes
  assign instr_o = prog[pc_i];
  // unselected read shows the inverse, so a stale byte never looks valid
  assign dmem_rdata_o = instr_o.mem ? dmem[instr_o.data] : ~dmem[instr_o.data];

  // store port: one write per we pulse
  always @(posedge ref_clk_i) begin
    if (dmem_wr_i.we) begin
      dmem[dmem_wr_i.addr] <= dmem_wr_i.data;
    end
  end
endmodule : rfms_mem_model

// ### verification/tb_top.sv
// tb_top: self-checking bench for the flow/move/shift executor.
// assumes the memory model answers fetches and loads in the same cycle.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk_i = 1'b0; // core clock, 10 ns period
  logic srst_i = 1'b1; // synchronous reset, held at start
  rfms_pkg::rfms_instr_type instr; // word fetched at pc
  logic [7:0] dmem_rdata; // data memory read byte
  logic [15:0] pc_o; // program counter
  logic [7:0] acc_o; // accumulator
  rfms_pkg::rfms_flags_type flags_o; // c, v, z
  logic [15:0] program_index_o; // program index
  logic [7:0] status_o; // status register
  logic global_irq_enable_o; // status bit 5
  rfms_pkg::rfms_dmem_wr_type dmem_wr_o; // store request
  int fails = 0; // mismatches seen
  int checks_done = 0; // comparisons made

  // free-running core clock
  always #5 ref_clk_i = ~ref_clk_i;

  rfms_exec rfms_exec_inst (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .instr_i(instr), .dmem_rdata_i(dmem_rdata),
    .pc_o(pc_o), .acc_o(acc_o), .flags_o(flags_o), .program_index_o(program_index_o),
    .status_o(status_o), .global_irq_enable_o(global_irq_enable_o), .dmem_wr_o(dmem_wr_o)
  );

  rfms_mem_model rfms_mem_model_inst (
    .ref_clk_i(ref_clk_i), .pc_i(pc_o), .dmem_wr_i(dmem_wr_o), .instr_o(instr),
    .dmem_rdata_o(dmem_rdata)
  );

  // build a word from its fields
  function automatic logic [21:0] w(input logic [4:0] op, input logic mem,
      input logic [3:0] dst, input logic [3:0] src, input logic [7:0] data);
    return {op, mem, dst, src, data};
  endfunction : w

  // word with a 16-bit target spread over dst, src and data
  function automatic logic [21:0] wt(input logic [4:0] op, input logic [15:0] t);
    return {op, 1'b0, t};
  endfunction : wt

  // compare a value of up to 17 bits
  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // compare one flag bit
  task automatic chkb(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chkb

  // place a word at the current pc and let one edge execute it
  task automatic exec(input logic [21:0] word);
    rfms_mem_model_inst.prog[pc_o] = word;
    @(posedge ref_clk_i);
    #1;
  endtask : exec

  // short reset between scenarios, released just after an edge
  task automatic restart;
    srst_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    srst_i = 1'b0;
  endtask : restart

  // execute and check pc and program index
  task automatic fl(input logic [21:0] word, input logic [15:0] epc, input logic [15:0] eip);
    exec(word);
    chk(pc_o, epc, "pc");
    chk(program_index_o, eip, "index");
  endtask : fl

  // execute a load-type word and check accumulator, zero and no store
  task automatic mv(input logic [21:0] word, input logic [7:0] eacc);
    exec(word);
    chk(acc_o, eacc, "acc");
    chkb(flags_o.z, eacc == 8'h00, "zero");
    chkb(dmem_wr_o.we, 1'b0, "no store");
  endtask : mv

  // execute a store and check the request and an untouched accumulator
  task automatic st(input logic [21:0] word, input logic [7:0] a, input logic [7:0] d,
      input logic [7:0] eacc);
    exec(word);
    chk(dmem_wr_o, {1'b1, a, d}, "store");
    chk(acc_o, eacc, "acc kept");
  endtask : st

  // every condition code, both target forms, three flag states
  task automatic t_cond;
    logic [6:0] tk [3] = '{7'b0101010, 7'b0100110, 7'b0011001};
    logic [15:0] base;
    for (int k = 0; k < 3; k++) begin
      for (int f = 0; f < 2; f++) begin
        for (int c = 0; c < 7; c++) begin
          restart();
          exec(w(rfms_pkg::OP_MOV_IMM, 1'b0, (k == 2) ? 4'h0 : rfms_pkg::REG_IPL, 4'h0,
            (k == 0) ? 8'h40 : (k == 2) ? 8'h81 : 8'h00));
          if (k == 2) begin
            exec(w(rfms_pkg::OP_SHL, 1'b0, 4'h0, 4'h0, 8'h00));
          end
          base = pc_o;
          exec(w((f == 1) ? rfms_pkg::OP_JCC_IP : rfms_pkg::OP_JCC_IMM, 1'b0, c[3:0],
            4'h5, 8'h50));
          chk(pc_o, !tk[k][c] ? base + 16'h0001 : (f == 0) ? 16'h5550 :
            (k == 0) ? 16'h0040 : 16'h0000, "branch");
        end
      end
    end
  endtask : t_cond

  // jumps, calls, returns, push and pop in one walk
  task automatic t_flow;
    restart();
    fl(w(rfms_pkg::OP_MOV_IMM, 1'b0, rfms_pkg::REG_IPL, 4'h0, 8'h40), 16'h0001, 16'h0040);
    fl(wt(rfms_pkg::OP_JMP_IMM, 16'h1234), 16'h1234, 16'h0040);
    fl(wt(rfms_pkg::OP_JMP_IP, 16'h0000), 16'h0040, 16'h0040);
    fl(wt(rfms_pkg::OP_CALL_IMM, 16'h0010), 16'h0010, 16'h0040);
    fl(wt(rfms_pkg::OP_CALL_IMM, 16'h0020), 16'h0020, 16'h0040);
    chkb(global_irq_enable_o, 1'b0, "enable before");
    fl(wt(rfms_pkg::OP_RETI, 16'h0000), 16'h0011, 16'h0040);
    chkb(global_irq_enable_o, 1'b1, "enable after");
    chk(status_o, 8'h20, "status");
    fl(wt(rfms_pkg::OP_RET, 16'h0000), 16'h0041, 16'h0040);
    fl(wt(rfms_pkg::OP_CALLS_IMM, 16'h0030), 16'h0030, 16'h0042);
    fl(wt(rfms_pkg::OP_PUSH, 16'h0000), 16'h0031, 16'h0042);
    fl(w(rfms_pkg::OP_MOV_IMM, 1'b0, rfms_pkg::REG_IPL, 4'h0, 8'h77), 16'h0032, 16'h0077);
    fl(wt(rfms_pkg::OP_POP, 16'h0000), 16'h0033, 16'h0042);
    fl(wt(rfms_pkg::OP_RETS, 16'h0000), 16'h0042, 16'h0042);
    fl(w(rfms_pkg::OP_MOV_IMM, 1'b0, rfms_pkg::REG_IPL, 4'h0, 8'h50), 16'h0043, 16'h0050);
    fl(wt(rfms_pkg::OP_CALL_IP, 16'h0000), 16'h0050, 16'h0050);
    fl(wt(rfms_pkg::OP_RET, 16'h0000), 16'h0044, 16'h0050);
    fl(wt(rfms_pkg::OP_CALLS_IP, 16'h0000), 16'h0050, 16'h0045);
    // a plain no-op and an undefined opcode both just step the counter
    fl(wt(rfms_pkg::OP_NOP, 16'h0000), 16'h0051, 16'h0045);
    fl(wt(5'h1F, 16'h0000), 16'h0052, 16'h0045);
  endtask : t_flow

  // loads, stores and both carry-conditioned moves
  task automatic t_move;
    restart();
    rfms_mem_model_inst.dmem[8'h20] = 8'hC3;
    mv(w(rfms_pkg::OP_MOV_IMM, 1'b0, 4'h1, 4'h0, 8'h00), 8'h00);
    mv(w(rfms_pkg::OP_MOV_IMM, 1'b0, 4'h2, 4'h0, 8'h5A), 8'h5A);
    mv(w(rfms_pkg::OP_MOV_LD, 1'b0, 4'h3, 4'h2, 8'h00), 8'h5A);
    mv(w(rfms_pkg::OP_MOV_LD, 1'b1, 4'h4, 4'h0, 8'h20), 8'hC3);
    st(w(rfms_pkg::OP_MOV_ST, 1'b0, 4'h0, 4'h4, 8'h21), 8'h21, 8'hC3, 8'hC3);
    st(w(rfms_pkg::OP_MOV_ST_IMM, 1'b0, 4'h2, 4'h2, 8'h99), 8'h22, 8'h99, 8'hC3);
    mv(w(rfms_pkg::OP_CMVD, 1'b0, 4'h5, 4'h2, 8'h00), 8'h5A);
    mv(w(rfms_pkg::OP_CMVS, 1'b0, 4'h6, 4'h4, 8'h00), 8'hC3);
    st(w(rfms_pkg::OP_MOV_ST, 1'b0, 4'h0, 4'h5, 8'h23), 8'h23, 8'h5A, 8'hC3);
    st(w(rfms_pkg::OP_MOV_ST, 1'b0, 4'h0, 4'h6, 8'h24), 8'h24, 8'h00, 8'hC3);
    mv(w(rfms_pkg::OP_SHL, 1'b0, 4'h4, 4'h4, 8'h00), 8'h86);
    mv(w(rfms_pkg::OP_CMVD, 1'b0, 4'h7, 4'h2, 8'h00), 8'h5A);
    mv(w(rfms_pkg::OP_CMVS, 1'b0, 4'h8, 4'h2, 8'h00), 8'h5A);
    st(w(rfms_pkg::OP_MOV_ST, 1'b0, 4'h0, 4'h7, 8'h25), 8'h25, 8'h00, 8'h5A);
    st(w(rfms_pkg::OP_MOV_ST, 1'b0, 4'h0, 4'h8, 8'h26), 8'h26, 8'h5A, 8'h5A);
    st(w(rfms_pkg::OP_MOV_ST, 1'b0, 4'h0, 4'h3, 8'h27), 8'h27, 8'h5A, 8'h5A);
  endtask : t_move

  // every shift with carry in 0 and 1, register and memory sources
  task automatic t_shift;
    logic [4:0] ops [5] = '{rfms_pkg::OP_SHL, rfms_pkg::OP_SHLC, rfms_pkg::OP_SHR,
      rfms_pkg::OP_SHRC, rfms_pkg::OP_SHRA};
    logic [7:0] v;
    logic [7:0] r;
    logic cin;
    restart();
    foreach (ops[i]) begin
      for (int j = 0; j < 4; j++) begin
        v = j[0] ? 8'h01 : 8'h81;
        cin = j[1];
        exec(w(rfms_pkg::OP_MOV_IMM, 1'b0, 4'h0, 4'h0, {cin, 7'h00}));
        exec(w(rfms_pkg::OP_SHL, 1'b0, 4'h0, 4'h0, 8'h00));
        exec(w(rfms_pkg::OP_MOV_IMM, 1'b0, 4'h1, 4'h0, v));
        rfms_mem_model_inst.dmem[8'h20] = v;
        case (i)
          0: r = {v[6:0], 1'b0};
          1: r = {v[6:0], cin};
          2: r = {1'b0, v[7:1]};
          3: r = {cin, v[7:1]};
          default: r = {v[7], v[7:1]};
        endcase
        // memory source when carry in is set, register source otherwise
        exec(w(ops[i], cin, 4'h2, 4'h1, 8'h20));
        chk(acc_o, r, "shift acc");
        chkb(flags_o.c, (i < 2) ? v[7] : v[0], "shift carry");
        chkb(flags_o.v, r[7] ^ v[7], "shift overflow");
        chkb(flags_o.z, r == 8'h00, "shift zero");
        exec(w(rfms_pkg::OP_MOV_ST, 1'b0, 4'h0, 4'h2, 8'h30));
        chk(dmem_wr_o, {1'b1, 8'h30, r}, "shift dest");
      end
    end
  endtask : t_shift

  // report counts and the verdict, then stop
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence: reset values first, then each scenario
  initial begin
    repeat (6) @(posedge ref_clk_i);
    #1;
    chk(pc_o, 17'h00000, "pc reset");
    chk(program_index_o, 17'h00000, "index reset");
    chk({acc_o, status_o}, 17'h00000, "acc status reset");
    chk(dmem_wr_o, 17'h00000, "store reset");
    // reset stays high here; the first scenario's restart releases it
    t_cond();
    t_flow();
    t_move();
    t_shift();
    tally_and_finish();
  end

  // watchdog: the scenarios need under 330 cycles; the limit is 20000 cycles
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
endmodule : tb_top
